// ---- logic/pim_core.v ----
`include "pim_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module pim_core #(
  parameter [4:0] VECTOR_BASE = 5'h00
) (
  input  wire       CLOCK_I,
  input  wire       RST_I,
  input  wire       CS_N_I,
  input  wire       RD_N_I,
  input  wire       WR_N_I,
  input  wire       ADDR_LSB_I,
  input  wire [7:0] DATA_I,
  input  wire       ACK_N_I,
  input  wire       WIDE_CPU_I,
  input  wire       AUTO_END_ACK_I,
  input  wire [7:0] REQUEST_LINE_I,
  output reg  [7:0] DATA_O,
  output wire       DATA_OE_O,
  output wire       INT_O
);
  // ------------------------------------------------------------
  // Strobe edge detection
  // ------------------------------------------------------------
  reg        rd_n_d_reg;
  reg        wr_n_d_reg;
  reg        ack_n_d_reg;
  reg        wr_cs_reg;
  reg  [7:0] service_level_reg;
  reg  [7:0] level_mask_reg;
  reg  [7:0] pending_request_reg;
  reg  [2:0] lowest_reg;
  reg        special_mask_reg;
  reg        read_isr_reg;
  reg        poll_reg;
  reg        rotate_auto_reg;
  reg  [1:0] ack_count_reg;
  reg  [2:0] ack_level_reg;
  reg        ack_hit_reg;
  wire       rd_fall  = rd_n_d_reg & ~RD_N_I & ~CS_N_I;
  wire       wr_rise  = ~wr_n_d_reg & WR_N_I & wr_cs_reg;
  wire       ack_fall = ack_n_d_reg & ~ACK_N_I;
  wire       ack_rise = ~ack_n_d_reg & ACK_N_I;
  wire [1:0] ack_last = WIDE_CPU_I ? `PIM_ACK_PULSES_16 : `PIM_ACK_PULSES_8;
  wire       is_init  = wr_rise & ~ADDR_LSB_I & DATA_I[`PIM_D_INIT_BIT];
  wire       is_mask  = wr_rise & ADDR_LSB_I;
  wire       is_eoi   = wr_rise & ~ADDR_LSB_I & ~DATA_I[`PIM_D_INIT_BIT] & ~DATA_I[`PIM_D_MODE_BIT];
  wire       is_mode  = wr_rise & ~ADDR_LSB_I & ~DATA_I[7] & ~DATA_I[`PIM_D_INIT_BIT]
                        & DATA_I[`PIM_D_MODE_BIT];
  // ------------------------------------------------------------
  // Sequence freeze
  // ------------------------------------------------------------
  // Request latching stops for a whole acknowledge sequence or an armed
  // poll, so the level picked at the first strobe cannot change under it
  wire       ack_busy = (ack_count_reg != 2'h0);
  wire       freeze   = ack_busy | poll_reg;
  // ------------------------------------------------------------
  // Priority resolution, rotated so lowest_reg+1 is highest
  // ------------------------------------------------------------
  reg  [2:0] req_lvl;
  reg        req_hit;
  reg  [2:0] isr_lvl;
  reg        isr_hit;
  reg  [2:0] blk_lvl;
  reg        blk_hit;
  reg  [2:0] idx;
  integer    k;
  wire [7:0] eligible = pending_request_reg & ~level_mask_reg;
  // Special mask mode leaves only the mask to inhibit; service bits block nothing
  wire [7:0] isr_eff  = special_mask_reg ? 8'h00 : service_level_reg;
  always @* begin
    req_lvl = 3'h0;
    req_hit = 1'b0;
    isr_lvl = 3'h0;
    isr_hit = 1'b0;
    blk_lvl = 3'h0;
    blk_hit = 1'b0;
    idx     = 3'h0;
    for (k = 7; k >= 0; k = k - 1) begin
      idx = lowest_reg + k[2:0] + 3'h1;
      if (eligible[idx]) begin
        req_lvl = idx;
        req_hit = 1'b1;
      end
      if (service_level_reg[idx]) begin
        isr_lvl = idx;
        isr_hit = 1'b1;
      end
      if (isr_eff[idx]) begin
        blk_lvl = idx;
        blk_hit = 1'b1;
      end
    end
  end
  // Rank 0 is highest; requests must outrank the highest blocking service
  wire [2:0] req_rank = req_lvl - lowest_reg - 3'h1;
  wire [2:0] blk_rank = blk_lvl - lowest_reg - 3'h1;
  wire       grant    = req_hit & (~blk_hit | (req_rank < blk_rank));
  assign INT_O = grant & ~poll_reg;
  // ------------------------------------------------------------
  // Register and sequence updates
  // ------------------------------------------------------------
  reg  [7:0] isr_next;
  reg  [7:0] irr_next;
  reg  [2:0] lowest_next;
  wire       poll_read = poll_reg & rd_fall;
  wire       auto_end  = AUTO_END_ACK_I & ack_rise & (ack_count_reg == ack_last);
  always @* begin
    isr_next    = service_level_reg;
    irr_next    = freeze ? pending_request_reg : (pending_request_reg | REQUEST_LINE_I);
    lowest_next = lowest_reg;
    if ((ack_fall & ~ack_busy & grant) | (poll_read & req_hit)) begin
      isr_next[req_lvl] = 1'b1;
      irr_next[req_lvl] = 1'b0;
    end
    if (auto_end & ack_hit_reg) begin
      isr_next[ack_level_reg] = 1'b0;
      if (rotate_auto_reg)
        lowest_next = ack_level_reg;
    end
    if (is_eoi) begin
      case (DATA_I[7:5])
        3'b001: if (isr_hit) begin
          isr_next[isr_lvl] = 1'b0;
          if (special_mask_reg)
            irr_next = irr_next | (pending_request_reg & level_mask_reg);
        end
        3'b011: isr_next[DATA_I[2:0]] = 1'b0;
        3'b101: if (isr_hit) begin
          isr_next[isr_lvl] = 1'b0;
          lowest_next       = isr_lvl;
        end
        3'b110: lowest_next = DATA_I[2:0];
        3'b111: begin
          isr_next[DATA_I[2:0]] = 1'b0;
          lowest_next           = DATA_I[2:0];
        end
        default: lowest_next = lowest_next;
      endcase
    end
  end
  // ------------------------------------------------------------
  // Strobe history
  // ------------------------------------------------------------
  // Delayed copies reset to the idle high level, so leaving reset never
  // looks like a strobe edge
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      rd_n_d_reg  <= 1'b1;
      wr_n_d_reg  <= 1'b1;
      ack_n_d_reg <= 1'b1;
      wr_cs_reg   <= 1'b0;
    end else begin
      rd_n_d_reg  <= RD_N_I;
      wr_n_d_reg  <= WR_N_I;
      ack_n_d_reg <= ACK_N_I;
      // Chip select is latched while write is low so the trailing edge still counts
      if (~WR_N_I) begin
        wr_cs_reg <= ~CS_N_I;
      end
    end
  end
  // ------------------------------------------------------------
  // Service, pending and priority state
  // ------------------------------------------------------------
  // Init only moves the priority base; service and pending bits are
  // left to the end commands, poll reads and the acknowledge sequence
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      service_level_reg   <= 8'h00;
      pending_request_reg <= 8'h00;
      lowest_reg          <= `PIM_LOWEST_RESET;
    end else begin
      service_level_reg   <= isr_next;
      pending_request_reg <= irr_next;
      if (is_init) begin
        lowest_reg <= `PIM_LOWEST_RESET;
      end else begin
        lowest_reg <= lowest_next;
      end
    end
  end
  // ------------------------------------------------------------
  // Acknowledge pulse counter
  // ------------------------------------------------------------
  // The level and grant are captured at the first pulse, so the auto end
  // clears the level that was really served even if requests moved since
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ack_count_reg <= 2'h0;
      ack_level_reg <= 3'h0;
      ack_hit_reg   <= 1'b0;
    end else begin
      if (ack_fall) begin
        if (~ack_busy) begin
          ack_count_reg <= 2'h1;
          ack_level_reg <= req_lvl;
          ack_hit_reg   <= grant;
        end else if (ack_count_reg != ack_last) begin
          ack_count_reg <= ack_count_reg + 2'h1;
        end
      end else if (ack_rise & (ack_count_reg == ack_last)) begin
        ack_count_reg <= 2'h0;
      end
    end
  end
  // ------------------------------------------------------------
  // Mask and mode flags
  // ------------------------------------------------------------
  // Later statements win: an init write overrides anything decoded with it
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      level_mask_reg   <= `PIM_MASK_RESET;
      special_mask_reg <= 1'b0;
      read_isr_reg     <= 1'b0;
      poll_reg         <= 1'b0;
      rotate_auto_reg  <= 1'b0;
    end else begin
      if (poll_read)
        poll_reg <= 1'b0;
      if (is_mask)
        level_mask_reg <= DATA_I;
      if (is_eoi & (DATA_I[7:5] == 3'b100))
        rotate_auto_reg <= 1'b1;
      if (is_eoi & (DATA_I[7:5] == 3'b000))
        rotate_auto_reg <= 1'b0;
      if (is_mode) begin
        if (DATA_I[`PIM_MODE_MWE_BIT])
          special_mask_reg <= DATA_I[`PIM_MODE_SMM_BIT];
        if (DATA_I[`PIM_MODE_RR_BIT])
          read_isr_reg <= DATA_I[`PIM_MODE_RIS_BIT];
        poll_reg <= DATA_I[`PIM_MODE_POLL_BIT];
      end
      if (is_init) begin
        level_mask_reg   <= `PIM_MASK_RESET;
        special_mask_reg <= 1'b0;
        read_isr_reg     <= 1'b0;
        rotate_auto_reg  <= 1'b0;
        poll_reg         <= 1'b0;
      end
    end
  end
  // ------------------------------------------------------------
  // Read data and vector output
  // ------------------------------------------------------------
  // The data output is only enabled while the host strobes the bus, so a
  // late vector never collides with another driver
  wire in_ack  = ~ACK_N_I;
  wire do_read = ~RD_N_I & ~CS_N_I;
  assign DATA_OE_O = do_read | (in_ack & ack_busy);
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      DATA_O <= 8'h00;
    end else if (ack_fall & ~ack_busy) begin
      DATA_O <= {VECTOR_BASE, req_lvl};
    end else if (rd_fall) begin
      if (ADDR_LSB_I)
        DATA_O <= level_mask_reg;
      else if (poll_reg)
        DATA_O <= {req_hit, 4'h0, req_lvl};
      else
        DATA_O <= read_isr_reg ? service_level_reg : pending_request_reg;
    end
  end
endmodule // pim_core
`default_nettype wire

// ---- logic/pim_defs.vh ----
`ifndef PIM_DEFS_VH
`define PIM_DEFS_VH
// Command word decode
`define PIM_D_INIT_BIT      4
`define PIM_D_MODE_BIT      3
`define PIM_EOI_SHIFT_BIT   7
`define PIM_EOI_SELECT_BIT  6
`define PIM_EOI_END_BIT     5
`define PIM_MODE_MWE_BIT    6
`define PIM_MODE_SMM_BIT    5
`define PIM_MODE_POLL_BIT   2
`define PIM_MODE_RR_BIT     1
`define PIM_MODE_RIS_BIT    0
`define PIM_POLL_FLAG_BIT   7
// Reset values and acknowledge pulse counts
`define PIM_MASK_RESET      8'h00
`define PIM_LOWEST_RESET    3'h7
`define PIM_ACK_PULSES_8    2'h3
`define PIM_ACK_PULSES_16   2'h2
`endif

// ---- tb/pim_core_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module pim_chk #(parameter [4:0] VECTOR_BASE = 5'h00) (
  input wire logic       CLOCK_I, RST_I, CS_N_I, RD_N_I, WR_N_I, ADDR_LSB_I, ACK_N_I, WIDE_CPU_I,
  input wire logic [7:0] DATA_I, DATA_O,
  input wire logic       DATA_OE_O, INT_O
);
  logic [7:0] mask_reg;
  logic       poll_reg;
  logic [1:0] ack_reg;
  // Shadow of mask, poll arming and acknowledge pulse count
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) {mask_reg, poll_reg, ack_reg} <= 11'h000;
    else begin
      if ($rose(WR_N_I) && !CS_N_I && ADDR_LSB_I) mask_reg <= DATA_I;
      if ($rose(WR_N_I) && !CS_N_I && !ADDR_LSB_I && DATA_I[4]) mask_reg <= 8'h00;
      if ($rose(WR_N_I) && !CS_N_I && !ADDR_LSB_I && !DATA_I[7] && !DATA_I[4] && DATA_I[3]) poll_reg <= DATA_I[2];
      else if ($fell(RD_N_I) && !CS_N_I) poll_reg <= 1'b0;
      if ($fell(ACK_N_I)) ack_reg <= (ack_reg == (WIDE_CPU_I ? 2'h1 : 2'h2)) ? 2'h0 : ack_reg + 2'h1;
    end
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  oe_read_a: assert property (!CS_N_I && !RD_N_I |-> DATA_OE_O) else $error("bus idle in read");
  oe_idle_a: assert property ((CS_N_I || RD_N_I) && ACK_N_I |-> !DATA_OE_O) else $error("bus driven idle");
  hold_out_a: assert property (RD_N_I && ACK_N_I && $past(RD_N_I) && $past(ACK_N_I) |-> $stable(DATA_O))
    else $error("read data moved");
  vector_a: assert property ($fell(ACK_N_I) && ack_reg == 2'h0 |-> ##3 DATA_O[7:3] == VECTOR_BASE)
    else $error("vector base wrong");
  mask_read_a: assert property ($fell(RD_N_I) && !CS_N_I && ADDR_LSB_I && !poll_reg |-> ##3 DATA_O == mask_reg)
    else $error("mask readback wrong");
  mask_full_a: assert property (mask_reg == 8'hFF && $past(mask_reg, 3) == 8'hFF |-> !INT_O)
    else $error("masked line interrupts");
  poll_int_a: assert property (poll_reg && $past(poll_reg, 2) |-> !INT_O) else $error("int during poll");
  poll_word_a: assert property ($fell(RD_N_I) && !CS_N_I && poll_reg |-> ##3 DATA_O[6:3] == 4'h0)
    else $error("poll filler bits set");
endmodule // pim_chk
bind pim_core pim_chk #(.VECTOR_BASE(VECTOR_BASE)) u_chk (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .CS_N_I(CS_N_I),
  .RD_N_I(RD_N_I), .WR_N_I(WR_N_I), .ADDR_LSB_I(ADDR_LSB_I), .ACK_N_I(ACK_N_I), .WIDE_CPU_I(WIDE_CPU_I),
  .DATA_I(DATA_I), .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O), .INT_O(INT_O));
`default_nettype wire

// ---- tb/pim_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module pim_host (
  input  wire logic       clk_i,
  output logic            cs_n_o, rd_n_o, wr_n_o, a0_o, ack_n_o,
  output logic [7:0]      data_o,
  input  wire logic [7:0] rdata_i
);
  initial {cs_n_o, rd_n_o, wr_n_o, a0_o, ack_n_o, data_o} = 13'h1F00;
  // Every strobe level lasts at least three cycles, above the one the core needs
  task automatic wr(input logic a, input logic [7:0] d);
    @(negedge clk_i);
    {cs_n_o, a0_o, wr_n_o, data_o} = {1'b0, a, 1'b0, d};
    repeat (3) @(negedge clk_i);
    wr_n_o = 1'b1;
    repeat (3) @(negedge clk_i);
    // Released bus shows the inverse so a stale byte never looks valid
    {cs_n_o, data_o} = {1'b1, ~d};
  endtask
  task automatic rd(input logic a, output logic [7:0] d);
    @(negedge clk_i);
    {cs_n_o, a0_o, rd_n_o} = {1'b0, a, 1'b0};
    repeat (4) @(negedge clk_i);
    d = rdata_i;
    {cs_n_o, rd_n_o} = 2'b11;
    repeat (3) @(negedge clk_i);
  endtask
  task automatic ack(input int n, output logic [7:0] v);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      ack_n_o = 1'b0;
      repeat (4) @(negedge clk_i);
      if (i == 0) v = rdata_i;
      ack_n_o = 1'b1;
      repeat (3) @(negedge clk_i);
    end
  endtask
endmodule // pim_host
`default_nettype wire

// ---- tb/priority_interrupt_modes_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module priority_interrupt_modes_tb;
  localparam logic [4:0] VBASE = 5'h15;
  logic clk = 1'b0, rst = 1'b1, wide = 1'b0, auto_end_ack = 1'b0;
  logic cs_n, rd_n, wr_n, a0, ack_n, oe, intr;
  logic [7:0] req = 8'h00, wd, rdat, got, m, q, p, s;
  int n_fail = 0;
  int num_checks = 0;
  // Rows: mask, request lines, expected poll word
  logic [23:0] rows [6] = '{24'h00_8180, 24'h00_8087, 24'h01_8187, 24'hFF_0F00, 24'h00_0000, 24'h0C_1C84};
  pim_core #(.VECTOR_BASE(VBASE)) u_dut (.CLOCK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .RD_N_I(rd_n),
    .WR_N_I(wr_n), .ADDR_LSB_I(a0), .DATA_I(wd), .ACK_N_I(ack_n), .WIDE_CPU_I(wide), .AUTO_END_ACK_I(auto_end_ack),
    .REQUEST_LINE_I(req), .DATA_O(rdat), .DATA_OE_O(oe), .INT_O(intr));
  pim_host u_host (.clk_i(clk), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .a0_o(a0), .ack_n_o(ack_n),
    .data_o(wd), .rdata_i(rdat));
  initial forever #5 clk = ~clk;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic do_reset();
    @(negedge clk);
    {rst, req, wide, auto_end_ack} = 11'h400;
    repeat (2) @(negedge clk);
    rst = 1'b0;
  endtask
  // Requests pulse briefly; the pending register must hold them
  task automatic sr(input logic [7:0] v);
    @(negedge clk);
    req = v;
    repeat (3) @(negedge clk);
    req = 8'h00;
    @(negedge clk);
  endtask
  task automatic rc(input logic [7:0] e);
    u_host.rd(1'b0, got);
    chk(got, e);
  endtask
  task automatic rr(input logic [7:0] c, input logic [7:0] e);
    u_host.wr(1'b0, c);
    rc(e);
  endtask
  initial begin
    #300_000;
    n_fail++;
    complete_run();
  end
  initial begin
    foreach (rows[i]) begin
      do_reset();
      {m, q, p} = rows[i];
      s = p[7] ? 8'h01 << p[2:0] : 8'h00;
      u_host.wr(1'b1, m);
      sr(q);
      chk({7'h00, intr}, {7'h00, |(q & ~m)});
      rr(8'h0C, p);
      rr(8'h0B, s);
      rr(8'h0A, q & ~s);
      $display("row %0d done", i);
    end
    do_reset();
    sr(8'h24);
    u_host.ack(3, got);
    chk(got, {VBASE, 3'h2});
    rr(8'h0B, 8'h04);
    chk({7'h00, intr}, 8'h00);
    sr(8'h02);
    chk({7'h00, intr}, 8'h01);
    u_host.ack(3, got);
    rc(8'h06);
    u_host.wr(1'b0, 8'h62);
    rc(8'h02);
    u_host.wr(1'b0, 8'h20);
    rc(8'h00);
    rr(8'h0A, 8'h20);
    u_host.wr(1'b0, 8'hC4);
    sr(8'h01);
    rr(8'h0C, 8'h85);
    u_host.wr(1'b0, 8'hE5);
    rr(8'h0C, 8'h80);
    u_host.wr(1'b0, 8'hA0);
    sr(8'h81);
    rr(8'h0C, 8'h87);
    $display("nesting and rotation done");
    do_reset();
    {auto_end_ack, wide} = 2'b11;
    u_host.wr(1'b0, 8'h80);
    sr(8'h08);
    u_host.ack(2, got);
    chk(got, {VBASE, 3'h3});
    rr(8'h0B, 8'h00);
    sr(8'h11);
    rr(8'h0C, 8'h84);
    $display("auto end done");
    do_reset();
    sr(8'h04);
    u_host.ack(3, got);
    sr(8'h40);
    u_host.wr(1'b0, 8'h68);
    chk({7'h00, intr}, 8'h01);
    u_host.wr(1'b0, 8'h48);
    chk({7'h00, intr}, 8'h00);
    u_host.wr(1'b0, 8'h68);
    u_host.wr(1'b1, 8'h40);
    chk({7'h00, intr}, 8'h00);
    u_host.rd(1'b1, got);
    chk(got, 8'h40);
    u_host.wr(1'b0, 8'h20);
    rr(8'h0A, 8'h40);
    u_host.wr(1'b0, 8'h10);
    u_host.rd(1'b1, got);
    chk(got, 8'h00);
    $display("special mask done");
    complete_run();
  end
endmodule // priority_interrupt_modes_tb
`default_nettype wire
